// ---- cgwd_checker.sv ----
// port checker for cgwd_top
// assumes one clock domain; bound below
`timescale 1ns/1ns
`default_nettype none
module cgwd_checker #(
    parameter int SECOND_CYCLES = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // host port
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    // status
    input wire logic cfg_open,
    input wire logic guard_running,
    input wire logic sys_reset
);
    localparam longint MAXRUN = 64'd15300 * SECOND_CYCLES + 4;
    longint run_r;
    wire wr_idx = clk_en && io_wr && io_addr == 16'h002e;
    wire key = wr_idx && io_wdata == 8'h87;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // longint: minute runs overflow an int at full clock rate
    always_ff @(posedge clk_sys or negedge reset_n)
        if (!reset_n)
            run_r <= 0;
        // a data port write may be a reload, so the bound starts over
        else if (clk_en)
            run_r <= (guard_running && !(io_wr && io_addr == 16'h002f))
                ? run_r + 1 : 0;
    chk_key_open: assert property (
        key && $past(key) && $past(reset_n) |=> cfg_open)
        else $error("unlock keys did not open");
    chk_relock: assert property (
        wr_idx && io_wdata == 8'haa |=> !cfg_open)
        else $error("relock ignored");
    chk_locked_read: assert property (
        !cfg_open && clk_en && io_rd && io_addr == 16'h002f
        |=> io_rdata == 8'hff) else $error("locked read leaked");
    chk_rdata_hold: assert property (
        !(clk_en && io_rd) |=> $stable(io_rdata))
        else $error("read data moved");
    chk_freeze: assert property (
        !clk_en |=> $stable({cfg_open, guard_running, sys_reset}))
        else $error("state moved while frozen");
    chk_pulse_len: assert property (
        $rose(sys_reset) |-> sys_reset[*8] ##1 sys_reset[*2] ##1 !sys_reset)
        else $error("reset pulse length wrong");
    chk_reset_cause: assert property (
        $rose(sys_reset) |-> $past(guard_running))
        else $error("reset without countdown");
    chk_start_load: assert property (
        $rose(guard_running) |-> $past(io_wr) && $past(io_wdata) != 8'h00)
        else $error("countdown began without load");
    chk_run_bound: assert property (run_r <= MAXRUN)
        else $error("countdown overran");
    cover property ($rose(sys_reset));
    cover property ($rose(cfg_open));
    cover property ($fell(guard_running) && !sys_reset);
endmodule
bind cgwd_top cgwd_checker #(.SECOND_CYCLES(SECOND_CYCLES)) u_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .cfg_open(cfg_open),
    .guard_running(guard_running), .sys_reset(sys_reset));
`default_nettype wire

// ---- cgwd_pkg.sv ----
// package for the countdown guard watchdog: port map, indices, codes, timing
// assumes a 10 MHz system clock and an 8-bit host i/o write/read strobe bus
package cgwd_pkg;
    localparam logic [15:0] PORT_INDEX = 16'h002e;
    localparam logic [15:0] PORT_DATA = 16'h002f;
    localparam logic [7:0] UNLOCK_KEY = 8'h87;
    localparam logic [7:0] LOCK_KEY = 8'haa;
    localparam logic [7:0] IDX_LDEV_SEL = 8'h07;
    localparam logic [7:0] IDX_DEV_ENABLE = 8'h30;
    localparam logic [7:0] IDX_ACTIVATE = 8'hf0;
    localparam logic [7:0] IDX_TIME_BASE = 8'hf5;
    localparam logic [7:0] IDX_TIMEOUT = 8'hf6;
    localparam logic [7:0] GUARD_LDEV = 8'h07;
    localparam logic [7:0] ENABLE_VAL = 8'h01;
    localparam logic [7:0] ACTIVATE_VAL = 8'h80;
    localparam logic [7:0] BASE_SECOND = 8'h71;
    localparam logic [7:0] BASE_MINUTE = 8'h79;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] RST_TIME_BASE = 8'h71;
    localparam int CLK_HZ = 10_000_000;
    localparam int SECOND_S = 1;
    localparam int SECOND_CYCLES = SECOND_S * CLK_HZ;
    localparam int MINUTE_S = 60;
    localparam int RESET_PULSE_NS = 1000;
    localparam int RESET_PULSE_CYCLES =
        (RESET_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
endpackage

// ---- cgwd_prescaler.sv ----
// time base prescaler: one tick per second or per minute
// assumes restart and minute_mode come from logic on clk_sys
`timescale 1ns/1ns
`default_nettype none
module cgwd_prescaler #(
    parameter int SECOND_CYCLES = cgwd_pkg::SECOND_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // link to core
    cgwd_tick_if.prescaler tk
);
    logic [23:0] sec_cnt_r;
    logic [5:0] min_cnt_r;
    logic tick_r;
    wire sec_wrap = (sec_cnt_r == 24'(SECOND_CYCLES - 1));
    wire min_wrap = (min_cnt_r == 6'(cgwd_pkg::MINUTE_S - 1));
    wire unit_done = sec_wrap && (!tk.minute_mode || min_wrap);
    assign tk.tick = tick_r;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sec_cnt_r <= '0;
            min_cnt_r <= '0;
            tick_r <= 1'b0;
        end
        else if (clk_en)
        begin
            // restart realigns the unit so a reload gives whole units
            if (tk.restart)
            begin
                sec_cnt_r <= '0;
                min_cnt_r <= '0;
                tick_r <= 1'b0;
            end
            else
            begin
                sec_cnt_r <= sec_wrap ? '0 : sec_cnt_r + 24'h000001;
                if (sec_wrap)
                    min_cnt_r <= min_wrap ? '0 : min_cnt_r + 6'h01;
                tick_r <= unit_done;
            end
        end
    end
endmodule
`default_nettype wire

// ---- cgwd_tick_if.sv ----
// carrier between the watchdog core and its time base prescaler
// assumes both ends run on clk_sys
`timescale 1ns/1ns
`default_nettype none
interface cgwd_tick_if;
    logic restart;
    logic minute_mode;
    logic tick;
    modport core (output restart, output minute_mode, input tick);
    modport prescaler (input restart, input minute_mode, output tick);
endinterface
`default_nettype wire

// ---- cgwd_top.sv ----
// countdown guard watchdog behind a two-port index/data config space
// assumes host i/o strobes are one-cycle pulses on clk_sys
// assumes sys_reset feeds a board reset that does not clear this block
// Operation
// RQ1 - count down from preset; pulse system reset when count reaches zero
// RQ2 - host loads a count and reloads it before it expires
// RQ3 - index port takes register index, data port carries its data
// RQ4 - two unlock keys in a row to index port open config space
// RQ5 - index 07h then 07h on data port selects guard device
// RQ6 - writing 01h at index 30h enables the guard device
// RQ7 - writing 80h at index F0h activates the guard function
// RQ8 - index F6h holds 8-bit count; 1..255 units of time base
// RQ9 - a count of zero disables timeout, no reset generated
// RQ10 - writing 71h at index F5h selects one second per unit
// RQ11 - writing 79h at index F5h selects one minute per unit
// RQ12 - each nonzero count write restarts countdown from the new value
`timescale 1ns/1ns
`default_nettype none
module cgwd_top #(
    parameter int SECOND_CYCLES = cgwd_pkg::SECOND_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // host i/o port
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // status and reset request
    output logic cfg_open,
    output logic guard_running,
    output logic sys_reset
);
    typedef enum logic [1:0] {LOCKED, HALF, OPEN} cgwd_lock_e;
    cgwd_lock_e lock_r, lock_nxt;
    logic [7:0] index_r;
    logic [7:0] ldev_r;
    logic [7:0] enable_r;
    logic [7:0] activate_r;
    logic [7:0] base_r;
    logic [7:0] count_r;
    logic [7:0] remain_r;
    logic running_r;
    logic [7:0] rdata_r;
    logic [3:0] rst_cnt_r;
    logic rst_r;
    logic open_r;
    cgwd_tick_if tk ();

    // held in restart while idle, so a load always starts a whole unit
    cgwd_prescaler #(.SECOND_CYCLES(SECOND_CYCLES)) u_pre (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .tk(tk)
    );

    // guard registers answer only with the guard device selected
    function automatic logic is_guard_reg(input logic [7:0] idx);
        return idx == cgwd_pkg::IDX_DEV_ENABLE
            || idx == cgwd_pkg::IDX_ACTIVATE
            || idx == cgwd_pkg::IDX_TIME_BASE
            || idx == cgwd_pkg::IDX_TIMEOUT;
    endfunction

    // decode
    wire hit_index = (io_addr == cgwd_pkg::PORT_INDEX); // RQ3
    wire hit_data = (io_addr == cgwd_pkg::PORT_DATA); // RQ3
    wire idx_wr = io_wr && hit_index;
    wire is_open = (lock_r == OPEN);
    wire dat_wr = io_wr && hit_data && is_open;
    wire sel_guard = (ldev_r == cgwd_pkg::GUARD_LDEV); // RQ5
    wire guard_acc = sel_guard && is_guard_reg(index_r);
    wire wr_ldev = dat_wr && index_r == cgwd_pkg::IDX_LDEV_SEL;
    wire wr_en = dat_wr && guard_acc && index_r == cgwd_pkg::IDX_DEV_ENABLE;
    wire wr_act = dat_wr && guard_acc && index_r == cgwd_pkg::IDX_ACTIVATE;
    wire wr_base = dat_wr && guard_acc && index_r == cgwd_pkg::IDX_TIME_BASE;
    wire wr_cnt = dat_wr && guard_acc && index_r == cgwd_pkg::IDX_TIMEOUT;
    wire armed = enable_r == cgwd_pkg::ENABLE_VAL // RQ6
        && activate_r == cgwd_pkg::ACTIVATE_VAL; // RQ7
    // only the two documented codes change the time base
    wire base_ok = io_wdata == cgwd_pkg::BASE_SECOND // RQ10
        || io_wdata == cgwd_pkg::BASE_MINUTE; // RQ11
    wire load = wr_cnt && io_wdata != 8'h00; // RQ12
    wire expire = running_r && tk.tick && remain_r == 8'h01; // RQ1
    // locked data port, foreign and unmapped reads float high like an idle bus; the index port always reads back index_r
    wire [7:0] rd_mux =
        hit_index ? index_r :
        !hit_data ? 8'hff :
        !is_open ? 8'hff :
        index_r == cgwd_pkg::IDX_LDEV_SEL ? ldev_r :
        !guard_acc ? 8'hff :
        index_r == cgwd_pkg::IDX_DEV_ENABLE ? enable_r :
        index_r == cgwd_pkg::IDX_ACTIVATE ? activate_r :
        index_r == cgwd_pkg::IDX_TIME_BASE ? base_r : count_r;

    assign tk.restart = load || !running_r;
    assign tk.minute_mode = (base_r == cgwd_pkg::BASE_MINUTE); // RQ11

    // unlock: two keys back to back, any other index write relocks halfway
    always_comb
    begin
        lock_nxt = lock_r;
        if (idx_wr)
        begin
            unique case (lock_r)
                LOCKED: lock_nxt = (io_wdata == cgwd_pkg::UNLOCK_KEY)
                    ? HALF : LOCKED; // RQ4
                HALF: lock_nxt = (io_wdata == cgwd_pkg::UNLOCK_KEY)
                    ? OPEN : LOCKED; // RQ4
                OPEN: lock_nxt = (io_wdata == cgwd_pkg::LOCK_KEY)
                    ? LOCKED : OPEN;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lock_r <= LOCKED;
            index_r <= cgwd_pkg::RST_REG;
            ldev_r <= cgwd_pkg::RST_REG;
            enable_r <= cgwd_pkg::RST_REG;
            activate_r <= cgwd_pkg::RST_REG;
            base_r <= cgwd_pkg::RST_TIME_BASE;
            count_r <= cgwd_pkg::RST_REG;
        end
        else if (clk_en)
        begin
            lock_r <= lock_nxt;
            if (idx_wr && is_open)
                index_r <= io_wdata; // RQ3
            if (wr_ldev)
                ldev_r <= io_wdata; // RQ5
            if (wr_en)
                enable_r <= io_wdata; // RQ6
            if (wr_act)
                activate_r <= io_wdata; // RQ7
            if (wr_base && base_ok)
                base_r <= io_wdata;
            if (wr_cnt)
                count_r <= io_wdata; // RQ8
        end
    end

    // countdown engine
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            remain_r <= 8'h00;
            running_r <= 1'b0;
        end
        else if (clk_en)
        begin
            // disarming stops quietly; only a run to zero resets the board
            if (wr_cnt && io_wdata == 8'h00)
                running_r <= 1'b0; // RQ9
            else if (load)
            begin
                remain_r <= io_wdata; // RQ12
                running_r <= armed;
            end
            else if (!armed || expire)
                running_r <= 1'b0;
            else if (running_r && tk.tick)
                remain_r <= remain_r - 8'h01; // RQ1
        end
    end

    // reset pulse, held long enough for the board's reset logic
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_cnt_r <= 4'h0;
            rst_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (expire)
            begin
                rst_cnt_r <= 4'(cgwd_pkg::RESET_PULSE_CYCLES);
                rst_r <= 1'b1; // RQ1
            end
            else if (rst_cnt_r > 4'h1)
                rst_cnt_r <= rst_cnt_r - 4'h1;
            else
            begin
                rst_cnt_r <= 4'h0;
                rst_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata_r <= 8'hff;
            open_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (io_rd)
                rdata_r <= rd_mux;
            open_r <= (lock_nxt == OPEN);
        end
    end

    // every output straight from a flop
    assign io_rdata = rdata_r;
    assign cfg_open = open_r;
    assign guard_running = running_r;
    assign sys_reset = rst_r;
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for cgwd_top
// assumes SECOND_CYCLES shortened to 20
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
$display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb;
    localparam int SC = 20;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic [15:0] io_addr = 16'h0000;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic [7:0] v;
    logic cfg_open;
    logic guard_running;
    logic sys_reset;
    int n_errors = 0;
    int n_checks = 0;
    // index, data, value read back
    logic [7:0] rows [6][3] = '{
        '{8'h30, 8'h01, 8'h01},
        '{8'hf0, 8'h80, 8'h80},
        '{8'hf5, 8'h79, 8'h79},
        '{8'hf5, 8'h33, 8'h79},
        '{8'hf5, 8'h71, 8'h71},
        '{8'hf6, 8'h00, 8'h00}};
    always #50 clk_sys = ~clk_sys;
    cgwd_top #(.SECOND_CYCLES(SC)) u_cgwd_top (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .cfg_open(cfg_open),
        .guard_running(guard_running), .sys_reset(sys_reset));
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // n > 1 holds the strobe for back to back writes
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
        input int n = 1);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        repeat (n) @(negedge clk_sys);
        io_wr = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] idx);
        wr(16'h002e, idx);
        io_addr = 16'h002f;
        io_rd = 1'b1;
        @(negedge clk_sys);
        io_rd = 1'b0;
        @(negedge clk_sys);
        v = io_rdata;
    endtask
    // load n units, optionally freeze f cycles, time the reset
    task automatic run(input int n, input int unit, input int f);
        int c;
        int p;
        c = 0;
        p = 0;
        wr(16'h002e, 8'hf6);
        wr(16'h002f, n[7:0]);
        clk_en = (f == 0);
        repeat (f) @(negedge clk_sys);
        clk_en = 1'b1;
        while (sys_reset !== 1'b1 && c < 2000)
        begin
            @(negedge clk_sys);
            c++;
        end
        while (sys_reset === 1'b1 && p < 50)
        begin
            @(negedge clk_sys);
            p++;
        end
        `CHK((n == 0) ? c == 2000 : (c >= n * unit * SC - 3 &&
            c <= n * unit * SC + 3), 1'b1)
        `CHK(p, (n == 0) ? 0 : cgwd_pkg::RESET_PULSE_CYCLES)
    endtask
    initial
    begin
        repeat (5) @(negedge clk_sys);
        reset_n = 1'b1;
        @(negedge clk_sys);
        `CHK({cfg_open, guard_running, sys_reset}, 3'b000)
        rd(8'hf6);
        `CHK(v, 8'hff)
        wr(16'h002e, 8'h87, 2);
        `CHK(cfg_open, 1'b1)
        wr(16'h002e, 8'h07);
        wr(16'h002f, 8'h07);
        rd(8'h07);
        `CHK(v, 8'h07)
        foreach (rows[i])
        begin
            wr(16'h002e, rows[i][0]);
            wr(16'h002f, rows[i][1]);
            rd(rows[i][0]);
            `CHK(v, rows[i][2])
        end
        io_addr = 16'h0080;
        io_rd = 1'b1;
        @(negedge clk_sys);
        io_rd = 1'b0;
        @(negedge clk_sys);
        `CHK(io_rdata, 8'hff)
        run(3, 1, 0);
        wr(16'h002e, 8'hf6);
        wr(16'h002f, 8'h03);
        repeat (40) @(negedge clk_sys);
        `CHK({guard_running, sys_reset}, 2'b10)
        run(2, 1, 0);
        wr(16'h002e, 8'hf6);
        wr(16'h002f, 8'h03);
        repeat (20) @(negedge clk_sys);
        run(0, 1, 0);
        run(3, 1, 100);
        wr(16'h002e, 8'hf5);
        wr(16'h002f, 8'h79);
        run(1, 60, 0);
        wr(16'h002e, 8'haa);
        `CHK(cfg_open, 1'b0)
        wr(16'h002e, 8'h87, 2);
        wr(16'h002e, 8'hf6);
        wr(16'h002f, 8'h05);
        reset_n = 1'b0;
        @(negedge clk_sys);
        `CHK({cfg_open, guard_running, sys_reset}, 3'b000)
        reset_n = 1'b1;
        @(negedge clk_sys);
        wr(16'h002e, 8'h87, 2);
        rd(8'h07);
        `CHK(v, 8'h00)
        test_done;
    end
    // whole run needs about 4000 cycles
    initial
    begin
        #(1_000_000);
        n_errors++;
        test_done;
    end
endmodule
`default_nettype wire
